// >>> verilog/ssrc_core.sv
// Supply sequencing core with restart classification and Wishbone registers
// Contract
// (RULE_01) A UV, OV or termination induced power-off or shutdown is a fault and loads 2.4 s.
// (RULE_02) A pin or bus command power-off or shutdown loads 12.5 ms and never limits retries.
// (RULE_03) Restarts after fault events are counted and stop when the retry budget is used up.
// (RULE_04) The error output pin does not depend on the fault or command classification.
// (RULE_05) The next position turns off only when every channel of the previous one is low.
// (RULE_06) Channels of one position are switched together with no ordering among them.
// (RULE_07) A forced shutdown drops every enable at once regardless of positions.
// (RULE_08) Termination is declared when UV or OFF threshold is not reached before timeout.
// (RULE_09) A restart starts power-on sequencing, and the first power-up is a restart.
// (RULE_10) A power-on delay runs from restart timer expiry to each enable going active.
// (RULE_11) A programmable power-off delay runs from input going off to enable going low.
// (RULE_12) Each 10-bit reading is compared against programmed UV and OV limits.
// (RULE_13) Sequencing stays inactive while the supply lockout is asserted.
// (RULE_14) The restart timer starts after power-off completes; restart waits for expiry.
`timescale 1ns/1ps
`include "ssrc_params.svh"
module ssrc_core #(
    parameter int NCH        = 6,
    parameter int NPOS       = 4,
    parameter int FAULT_DLY  = `SSRC_FAULT_DLY_CYC,
    parameter int CMD_DLY    = `SSRC_CMD_DLY_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire ssrc_pkg::ssrc_wb_req_s wb_req_i,
    output ssrc_pkg::ssrc_wb_rsp_s     wb_rsp_o,
    input  wire logic [NCH*10-1:0]     reading_i,
    input  wire logic                  supply_lockout_i,
    input  wire logic                  shutdown_request_low_i,
    input  wire logic                  power_request_pin_i,
    output logic [NCH-1:0]             supply_enable_output_o,
    output logic                       error_o,
    output logic                       irq_o
);
    import ssrc_pkg::*;

    localparam int PW = $clog2(NPOS);

    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    logic [2:0] pins_s;
    ssrc_sync #(.W(3)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   ({~supply_lockout_i, ~shutdown_request_low_i, power_request_pin_i}),
        .level_o (pins_s)
    );
    // Lockout and shutdown travel inverted so the chain resets to locked, no shutdown
    logic lock_s, fs_n_s, pwr_s;
    assign lock_s = ~pins_s[2];
    assign fs_n_s = ~pins_s[1];
    assign pwr_s  = pins_s[0];

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    logic [2:0]        ctrl_pulse;
    logic [31:0]       tmo_q, tmo_d;
    logic [15:0]       on_dly_q, on_dly_d, off_dly_q, off_dly_d;
    logic [7:0]        retry_q, retry_d;
    logic [NCH*PW-1:0] pos_q, pos_d;
    logic [9:0]        uv_q [NCH], uv_d [NCH];
    logic [9:0]        ov_q [NCH], ov_d [NCH];
    logic [9:0]        offth_q [NCH], offth_d [NCH];
    logic [4:0]        ist_q, ist_d, ien_q, ien_d, ev;
    ssrc_wb_rsp_s      rsp_q, rsp_d;

    // Channel position lookup
    function automatic logic [PW-1:0] pos_of(input logic [NCH*PW-1:0] p, input int ch);
        pos_of = p[ch*PW +: PW];
    endfunction

    //------------------------------------------------------------------
    // Comparators on 10-bit readings
    //------------------------------------------------------------------
    logic [NCH-1:0] under_threshold, over_threshold, below_off;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_cmp
            assign under_threshold[g] = reading_i[g*10 +: 10] < uv_q[g];   // see RULE_12
            assign over_threshold[g]  = reading_i[g*10 +: 10] > ov_q[g];   // see RULE_12
            assign below_off[g]       = reading_i[g*10 +: 10] < offth_q[g];
        end
    endgenerate

    //------------------------------------------------------------------
    // Sequencer state
    //------------------------------------------------------------------
    ssrc_state_e       st_q, st_d;
    logic [PW-1:0]     cur_q, cur_d;
    logic [31:0]       tmr_q, tmr_d, wd_q, wd_d;
    logic              fault_q, fault_d, dly_q, dly_d;
    logic [7:0]        used_q, used_d;
    logic [NCH-1:0]    en_q, en_d;
    logic              err_q, err_d;

    logic [NCH-1:0] grp, prev_grp;
    logic           cmd_off, cmd_force;
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            grp[c]      = pos_of(pos_q, c) == cur_q;                       // see RULE_06
            prev_grp[c] = pos_of(pos_q, c) == PW'(cur_q + PW'(1));
        end
    end
    assign cmd_off   = !pwr_s || ctrl_pulse[`SSRC_CTRL_PWR_OFF];
    assign cmd_force = !fs_n_s || ctrl_pulse[`SSRC_CTRL_FORCE];

    // Next state of the sequencer
    always_comb begin
        st_d = st_q; cur_d = cur_q; tmr_d = tmr_q; wd_d = wd_q;
        fault_d = fault_q; used_d = used_q; en_d = en_q; err_d = err_q;
        dly_d = dly_q; ev = '0;
        if (lock_s) begin                                                   // see RULE_13
            st_d = SSRC_ST_LOCK; en_d = '0; tmr_d = '0; used_d = '0;
        end else begin
            unique case (st_q)
                SSRC_ST_LOCK: begin
                    st_d = SSRC_ST_RESTART; fault_d = 1'b0;                 // see RULE_09
                    tmr_d = 32'(CMD_DLY);
                end
                SSRC_ST_RESTART: begin
                    if (tmr_q != 0) begin
                        tmr_d = tmr_q - 32'd1;                              // see RULE_14
                    end else if (!pwr_s || !fs_n_s) begin
                        tmr_d = '0;
                    end else if (fault_q && used_q >= retry_q) begin
                        st_d = SSRC_ST_HALT;                                // see RULE_03
                        ev[`SSRC_IRQ_RETRY_OUT] = 1'b1;
                    end else begin
                        if (fault_q) used_d = used_q + 8'd1;                // see RULE_03
                        st_d = SSRC_ST_ON; cur_d = '0; dly_d = 1'b1;        // see RULE_09
                        tmr_d = 32'(on_dly_q); wd_d = tmo_q;
                    end
                end
                SSRC_ST_ON: begin
                    if (dly_q) begin
                        if (tmr_q != 0) tmr_d = tmr_q - 32'd1;              // see RULE_10
                        else begin
                            en_d = en_q | grp; dly_d = 1'b0;                // see RULE_06
                        end
                    end else if ((grp & under_threshold) == '0) begin
                        if (cur_q == PW'(NPOS - 1)) begin
                            st_d = SSRC_ST_UP; ev[`SSRC_IRQ_UP] = 1'b1;
                        end else begin
                            cur_d = cur_q + PW'(1); dly_d = 1'b1;
                            tmr_d = 32'(on_dly_q); wd_d = tmo_q;
                        end
                    end else if (wd_q == 0) begin
                        ev[`SSRC_IRQ_TERM] = 1'b1; err_d = 1'b1;            // see RULE_08
                    end else wd_d = wd_q - 32'd1;
                    if (st_q == SSRC_ST_ON && !dly_q && wd_q == 0 &&
                        (grp & under_threshold) != '0) begin
                        st_d = SSRC_ST_OFF; fault_d = 1'b1;                 // see RULE_01
                        cur_d = cur_q; dly_d = 1'b0; wd_d = tmo_q;
                    end
                end
                SSRC_ST_UP: begin
                    if ((en_q & (under_threshold | over_threshold)) != '0) begin
                        st_d = SSRC_ST_OFF; fault_d = 1'b1;                 // see RULE_01
                        ev[`SSRC_IRQ_FAULT] = 1'b1; err_d = 1'b1;
                        cur_d = PW'(NPOS - 1); dly_d = 1'b1; tmr_d = 32'(off_dly_q);
                    end else if (cmd_off) begin
                        st_d = SSRC_ST_OFF; fault_d = 1'b0;                 // see RULE_02
                        ev[`SSRC_IRQ_CMD] = 1'b1; used_d = '0;
                        cur_d = PW'(NPOS - 1); dly_d = 1'b1; tmr_d = 32'(off_dly_q);
                    end
                    wd_d = tmo_q;
                end
                SSRC_ST_OFF: begin
                    // Wait for previous position to fall before switching this one
                    if (dly_q) begin
                        if (cur_q != PW'(NPOS - 1) && (prev_grp & ~below_off) != '0) begin
                            if (wd_q == 0) begin                            // see RULE_08
                                ev[`SSRC_IRQ_TERM] = 1'b1; err_d = 1'b1;
                                fault_d = 1'b1; en_d = '0;                  // see RULE_01
                                st_d = SSRC_ST_RESTART; tmr_d = 32'(FAULT_DLY);
                            end else wd_d = wd_q - 32'd1;                   // see RULE_05
                        end else if (tmr_q != 0) tmr_d = tmr_q - 32'd1;     // see RULE_11
                        else begin
                            en_d = en_q & ~grp; dly_d = 1'b0; wd_d = tmo_q; // see RULE_06
                        end
                    end else if (cur_q == '0) begin
                        st_d = SSRC_ST_RESTART;                             // see RULE_14
                        tmr_d = fault_q ? 32'(FAULT_DLY) : 32'(CMD_DLY);    // see RULE_01
                    end else begin
                        cur_d = cur_q - PW'(1); dly_d = 1'b1; tmr_d = 32'(off_dly_q);
                    end
                end
                SSRC_ST_HALT: begin
                    if (ctrl_pulse[`SSRC_CTRL_POWER_REQUEST_PIN]) begin
                        st_d = SSRC_ST_RESTART; used_d = '0; fault_d = 1'b0;
                        tmr_d = 32'(CMD_DLY);
                    end
                end
            endcase
            // Forced shutdown overrides the sequence
            if (st_q != SSRC_ST_LOCK && st_q != SSRC_ST_HALT && (cmd_force ||
                (st_q == SSRC_ST_ON && (en_q & over_threshold) != '0))) begin
                en_d = '0;                                                  // see RULE_07
                st_d = SSRC_ST_RESTART;
                fault_d = !cmd_force;                                       // see RULE_02
                tmr_d = cmd_force ? 32'(CMD_DLY) : 32'(FAULT_DLY);          // see RULE_01
                if (cmd_force) used_d = '0;
                if (!cmd_force) err_d = 1'b1;                               // see RULE_04
                ev[`SSRC_IRQ_CMD]   = cmd_force;
                ev[`SSRC_IRQ_FAULT] = !cmd_force;
            end
        end
        // Error pin follows only UV/OV/termination, not restart class
        if (ctrl_pulse[`SSRC_CTRL_POWER_REQUEST_PIN]) err_d = 1'b0;                  // see RULE_04
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= SSRC_ST_LOCK; cur_q <= '0; tmr_q <= '0; wd_q <= '0;
            fault_q <= 1'b0; used_q <= '0; en_q <= '0; err_q <= 1'b0; dly_q <= 1'b0;
        end else begin
            st_q <= st_d; cur_q <= cur_d; tmr_q <= tmr_d; wd_q <= wd_d;
            fault_q <= fault_d; used_q <= used_d; en_q <= en_d; err_q <= err_d;
            dly_q <= dly_d;
        end
    end

    //------------------------------------------------------------------
    // Wishbone slave
    //------------------------------------------------------------------
    logic       acc;
    logic [7:0] a;
    assign acc = wb_req_i.cyc && wb_req_i.stb && !rsp_q.ack;
    assign a   = wb_req_i.adr;

    // Register writes, reads and interrupt bookkeeping
    always_comb begin
        tmo_d = tmo_q; on_dly_d = on_dly_q; off_dly_d = off_dly_q; retry_d = retry_q;
        pos_d = pos_q; uv_d = uv_q; ov_d = ov_q; offth_d = offth_q; ien_d = ien_q;
        ctrl_pulse = '0; rsp_d.ack = acc; rsp_d.dat = '0;
        ist_d = ist_q;
        if (acc && wb_req_i.we) begin
            unique case (a)
                `SSRC_OFF_CTRL:    ctrl_pulse = wb_req_i.dat[2:0];
                `SSRC_OFF_IRQ_CLR: ist_d = ist_q & ~wb_req_i.dat[4:0];
                `SSRC_OFF_IRQ_EN:  ien_d = wb_req_i.dat[4:0];
                `SSRC_OFF_TIMEOUT: tmo_d = wb_req_i.dat;
                `SSRC_OFF_ON_DLY:  on_dly_d = wb_req_i.dat[15:0];
                `SSRC_OFF_OFF_DLY: off_dly_d = wb_req_i.dat[15:0];
                `SSRC_OFF_RETRY:   retry_d = wb_req_i.dat[7:0];
                `SSRC_OFF_CHPOS:   pos_d = wb_req_i.dat[NCH*PW-1:0];
                default: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (a == `SSRC_OFF_UV + 8'(c*4)) uv_d[c] = wb_req_i.dat[9:0];
                        if (a == `SSRC_OFF_OV + 8'(c*4)) ov_d[c] = wb_req_i.dat[9:0];
                        if (a == `SSRC_OFF_OFFTH + 8'(c*4)) offth_d[c] = wb_req_i.dat[9:0];
                    end
                end
            endcase
        end else if (acc) begin
            unique case (a)
                `SSRC_OFF_STAT:    rsp_d.dat = {8'h00, used_q, NCH'(en_q), 4'h0, st_q};
                `SSRC_OFF_IRQ_STAT: rsp_d.dat = {27'h0, ist_q};
                `SSRC_OFF_IRQ_EN:  rsp_d.dat = {27'h0, ien_q};
                `SSRC_OFF_TIMEOUT: rsp_d.dat = tmo_q;
                `SSRC_OFF_ON_DLY:  rsp_d.dat = {16'h0, on_dly_q};
                `SSRC_OFF_OFF_DLY: rsp_d.dat = {16'h0, off_dly_q};
                `SSRC_OFF_RETRY:   rsp_d.dat = {24'h0, retry_q};
                `SSRC_OFF_CHPOS:   rsp_d.dat = 32'(pos_q);
                default: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (a == `SSRC_OFF_UV + 8'(c*4)) rsp_d.dat = {22'h0, uv_q[c]};
                        if (a == `SSRC_OFF_OV + 8'(c*4)) rsp_d.dat = {22'h0, ov_q[c]};
                        if (a == `SSRC_OFF_OFFTH + 8'(c*4)) rsp_d.dat = {22'h0, offth_q[c]};
                    end
                end
            endcase
        end
        ist_d = ist_d | ev;                                                // set beats clear
    end

    // Register file flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmo_q <= `SSRC_RST_TIMEOUT; on_dly_q <= `SSRC_RST_ON_DLY;
            off_dly_q <= `SSRC_RST_OFF_DLY; retry_q <= `SSRC_RST_RETRY;
            pos_q <= '0; ist_q <= '0; ien_q <= '0; rsp_q <= '0;
            for (int c = 0; c < NCH; c++) begin
                uv_q[c] <= 10'h000; ov_q[c] <= 10'h3FF; offth_q[c] <= 10'h000;
            end
        end else begin
            tmo_q <= tmo_d; on_dly_q <= on_dly_d; off_dly_q <= off_dly_d;
            retry_q <= retry_d; pos_q <= pos_d; ist_q <= ist_d; ien_q <= ien_d;
            rsp_q <= rsp_d; uv_q <= uv_d; ov_q <= ov_d; offth_q <= offth_d;
        end
    end

    // Interrupt output register
    logic irq_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) irq_q <= 1'b0;
        else       irq_q <= |(ist_d & ien_d);
    end

    assign wb_rsp_o               = rsp_q;
    assign supply_enable_output_o = en_q;
    assign error_o                = err_q;
    assign irq_o                  = irq_q;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    sequence s_force;
        st_q != SSRC_ST_LOCK && st_q != SSRC_ST_HALT && !lock_s && cmd_force;
    endsequence
    a_force_all_off: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_07
        s_force |=> en_q == '0) else $error("forced shutdown left an enable on");
    a_lock_idle: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_13
        lock_s |=> st_q == SSRC_ST_LOCK && en_q == '0) else $error("active in lockout");
    a_cmd_delay: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_02
        s_force |=> tmr_q == 32'(CMD_DLY) && !fault_q) else $error("command delay wrong");
    a_wb_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        rsp_q.ack |=> !rsp_q.ack) else $error("ack held two cycles");
    a_retry_halt: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_03
        $rose(st_q == SSRC_ST_HALT) |-> fault_q && used_q >= retry_q)
        else $error("halted without using up retries");
    a_cmd_no_err: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_04
        ev[`SSRC_IRQ_CMD] && !ev[`SSRC_IRQ_FAULT] && !ev[`SSRC_IRQ_TERM] && !err_q
        |=> !err_q) else $error("command event raised the error pin");
endmodule // ssrc_core

// >>> verilog/ssrc_params.svh
// Constants of the supply sequence restart controller
`ifndef SSRC_PARAMS_SVH
`define SSRC_PARAMS_SVH

// Clock and restart timing
`define SSRC_CLK_HZ          40000000
`define SSRC_FAULT_DLY_MS    2400
`define SSRC_CMD_DLY_US      12500
`define SSRC_FAULT_DLY_CYC   ((`SSRC_CLK_HZ / 1000) * `SSRC_FAULT_DLY_MS)
`define SSRC_CMD_DLY_CYC     ((`SSRC_CLK_HZ / 1000000) * `SSRC_CMD_DLY_US)

// Register byte offsets
`define SSRC_OFF_CTRL        8'h00
`define SSRC_OFF_STAT        8'h04
`define SSRC_OFF_IRQ_STAT    8'h08
`define SSRC_OFF_IRQ_CLR     8'h0C
`define SSRC_OFF_IRQ_EN      8'h10
`define SSRC_OFF_TIMEOUT     8'h14
`define SSRC_OFF_ON_DLY      8'h18
`define SSRC_OFF_OFF_DLY     8'h1C
`define SSRC_OFF_RETRY       8'h20
`define SSRC_OFF_CHPOS       8'h24
`define SSRC_OFF_UV          8'h40
`define SSRC_OFF_OV          8'h60
`define SSRC_OFF_OFFTH       8'h80

// Control register fields
`define SSRC_CTRL_PWR_OFF    0
`define SSRC_CTRL_FORCE      1
`define SSRC_CTRL_POWER_REQUEST_PIN     2

// Interrupt status fields
`define SSRC_IRQ_FAULT       0
`define SSRC_IRQ_CMD         1
`define SSRC_IRQ_TERM        2
`define SSRC_IRQ_RETRY_OUT   3
`define SSRC_IRQ_UP          4

// Reset values
`define SSRC_RST_TIMEOUT     32'h0000_FFFF
`define SSRC_RST_ON_DLY      16'h0028
`define SSRC_RST_OFF_DLY     16'h0028
`define SSRC_RST_RETRY       8'h03

`endif

// >>> verilog/ssrc_pkg.sv
// Types of the supply sequence restart controller
package ssrc_pkg;

    typedef enum logic [5:0] {
        SSRC_ST_LOCK    = 6'b000001,
        SSRC_ST_RESTART = 6'b000010,
        SSRC_ST_ON      = 6'b000100,
        SSRC_ST_UP      = 6'b001000,
        SSRC_ST_OFF     = 6'b010000,
        SSRC_ST_HALT    = 6'b100000
    } ssrc_state_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } ssrc_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ssrc_wb_rsp_s;

endpackage

// >>> verilog/ssrc_sync.sv
// Three-stage pin synchroniser with second and third stage agreement
`timescale 1ns/1ps
module ssrc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [W-1:0] lvl_d;

    // Accept a change only when stages two and three agree
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    // Synchroniser chain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_o = lvl_q;
endmodule // ssrc_sync

// >>> testbench/ssrc_conv_model.sv
// Behavioural model of the converters behind the enable outputs
`timescale 1ns/1ps
module ssrc_conv_model #(
    parameter int NCH = 6
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [NCH-1:0]    en_i,
    input  wire logic              slow_i,
    input  wire logic              ov_i,
    input  wire logic              dead_i,
    output logic      [NCH*10-1:0] rd_o
);
    logic [9:0] v [NCH];
    // Ramp toward the set point while enabled and not dead, toward ground otherwise
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NCH; c++) begin
            if (rst_i)
                v[c] <= 10'h000;
            else if (en_i[c] && !dead_i)
                v[c] <= (v[c] > 10'h340) ? 10'h380 : v[c] + (slow_i ? 10'h008 : 10'h040);
            else
                v[c] <= (v[c] < 10'h040) ? 10'h000 : v[c] - (slow_i ? 10'h008 : 10'h040);
        end
    end
    // Reading bus; channel zero can be pushed above its limit
    always_comb begin
        for (int c = 0; c < NCH; c++)
            rd_o[c*10+:10] = (c == 0 && ov_i) ? 10'h3FF : v[c];
    end
endmodule // ssrc_conv_model

// >>> testbench/supply_sequence_restart_control_test.sv
// Self-checking bench of the sequencing core
`timescale 1ns/1ps
`include "ssrc_params.svh"
module supply_sequence_restart_control_test;
    import ssrc_pkg::*;
    logic         clk_i = 0;
    logic         rst_i = 1;
    ssrc_wb_req_s req = '0;
    ssrc_wb_rsp_s rsp;
    logic [59:0]  rd_v;
    logic [5:0]   en, en_q = '0;
    logic         lock = 1, shut_n = 1, err, irq;
    logic         slow = 0, ov = 0, dead = 0, casc = 0;
    logic [11:0]  pos_v = '0;
    logic [31:0]  exp_q[$], msk_q[$];
    int           fails = 0, cmp_count = 0, cyc_n = 0;

    ssrc_core #(.FAULT_DLY(20), .CMD_DLY(10)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(req), .wb_rsp_o(rsp), .reading_i(rd_v), .supply_lockout_i(lock),
        .shutdown_request_low_i(shut_n), .power_request_pin_i(1'b1),
        .supply_enable_output_o(en), .error_o(err), .irq_o(irq));
    ssrc_conv_model #(.NCH(6)) conv (.clk_i(clk_i), .rst_i(rst_i), .en_i(en),
        .slow_i(slow), .ov_i(ov), .dead_i(dead), .rd_o(rd_v));

    initial forever #12.5 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        cmp_count++;
        if (seen !== expd) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, expd);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b1, w, 4'hF, a, d};
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        req <= '0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_en(input logic [5:0] v);
        for (int i = 0; i < 3000 && en !== v; i++) @(posedge clk_i);
        chk(32'(en), 32'(v));
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk_i);
        chk(32'(irq), 32'h1);
    endtask
    task automatic stay_off(input int n);
        logic [5:0] s;
        s = '0;
        repeat (n) begin
            @(posedge clk_i);
            s |= en;
        end
        chk(32'(s), 32'h0);
    endtask
    task automatic print_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Read data checker: oldest note against each read answer
    always @(posedge clk_i) begin
        if (rsp.ack === 1'b1 && req.we === 1'b0 && exp_q.size() > 0)
            chk(rsp.dat & msk_q.pop_front(), exp_q.pop_front());
    end
    // Position order of every rising enable edge and, while casc is set, every falling one; timeout
    always @(posedge clk_i) begin
        en_q <= en;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 50000) begin
            fails++;
            print_verdict();
        end
        for (int c = 0; c < 6; c++)
            for (int d = 0; d < 6; d++) begin
                if (en[c] && !en_q[c] && pos_v[2*d+:2] <= pos_v[2*c+:2])
                    chk(32'(en[d]), 32'h1);
                if (casc && !en[c] && en_q[c] && pos_v[2*d+:2] >= pos_v[2*c+:2])
                    chk({en[d], pos_v[2*d+:2] > pos_v[2*c+:2] && rd_v[d*10+:10] >= 10'h080},
                        32'h0);
            end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(15));
        pos_v <= 12'($urandom);
        slow  <= 1'($urandom);
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rd(`SSRC_OFF_TIMEOUT, '1, `SSRC_RST_TIMEOUT);
        rd(`SSRC_OFF_ON_DLY, '1, 32'(`SSRC_RST_ON_DLY));
        rd(`SSRC_OFF_RETRY, '1, 32'(`SSRC_RST_RETRY));
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(8'hFC, '1, 32'h0);
        for (int c = 0; c < 6; c++) begin
            wr(`SSRC_OFF_UV + 8'(4*c), 32'h300);
            wr(`SSRC_OFF_OV + 8'(4*c), 32'h3F0);
            wr(`SSRC_OFF_OFFTH + 8'(4*c), 32'h080);
        end
        wr(`SSRC_OFF_CHPOS, 32'(pos_v));
        wr(`SSRC_OFF_ON_DLY, 32'h4);
        wr(`SSRC_OFF_OFF_DLY, 32'h4);
        wr(`SSRC_OFF_TIMEOUT, 32'h12C);
        wr(`SSRC_OFF_RETRY, 32'h1);
        wr(`SSRC_OFF_IRQ_EN, 32'h2);
        chk(32'(en), 32'h0);
        lock <= 0;
        wait_en(6'h3F);
        repeat (120) @(posedge clk_i);
        rd(`SSRC_OFF_STAT, 32'h3F, 32'h08);
        $display("test power_up done");
        casc <= 1;
        wr(`SSRC_OFF_CTRL, 32'h1);
        wait_en(6'h00);
        casc <= 0;
        stay_off(10);
        wait_irq();
        rd(`SSRC_OFF_IRQ_STAT, 32'h3, 32'h2);
        chk(32'(err), 32'h0);
        wr(`SSRC_OFF_IRQ_CLR, 32'h2);
        rd(`SSRC_OFF_IRQ_STAT, 32'h2, 32'h0);
        chk(32'(irq), 32'h0);
        wr(`SSRC_OFF_CTRL, 32'h4);
        wait_en(6'h3F);
        $display("test command_off done");
        shut_n <= 0;
        for (int i = 0; i < 100 && en === 6'h3F; i++) @(posedge clk_i);
        chk(32'(en), 32'h0);
        rd(`SSRC_OFF_IRQ_STAT, 32'h3, 32'h2);
        chk(32'(err), 32'h0);
        shut_n <= 1;
        wr(`SSRC_OFF_CTRL, 32'h4);
        wait_en(6'h3F);
        $display("test forced_off done");
        wr(`SSRC_OFF_IRQ_EN, 32'h8);
        repeat (120) @(posedge clk_i);
        ov <= 1;
        wait_en(6'h00);
        stay_off(20);
        wait_irq();
        chk(32'(en | {5'h0, ~err}), 32'h0);
        rd(`SSRC_OFF_STAT, 32'h3F, 32'h20);
        rd(`SSRC_OFF_IRQ_STAT, 32'h9, 32'h9);
        ov <= 0;
        wr(`SSRC_OFF_IRQ_CLR, 32'h1F);
        wr(`SSRC_OFF_CTRL, 32'h4);
        chk(32'(err), 32'h0);
        wait_en(6'h3F);
        $display("test fault_retry done");
        wr(`SSRC_OFF_IRQ_EN, 32'h4);
        dead <= 1;
        wait_irq();
        rd(`SSRC_OFF_IRQ_STAT, 32'h4, 32'h4);
        chk(32'(err), 32'h1);
        $display("test termination done");
        print_verdict();
    end
endmodule // supply_sequence_restart_control_test
